// >>> core/asc_top.sv
// converter sequencing control: registers, sample/convert sequencer, dma feed
// assumes a classic wishbone master and an analog core that returns its code
// on ANALOG_CODE_IN for the channel on CONVERT_CH_OUT at conversion end
`timescale 1ns/1ps
`default_nettype none
module asc_top
	import asc_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic RST_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	input wire logic IDLE_MODE_IN,
	input wire logic EXT_TRIG_IN,
	input wire logic TIMER_MATCH_IN,
	input wire logic [11:0] ANALOG_CODE_IN,
	output logic [3:0] SAMPLE_CH_OUT,
	output logic [1:0] CONVERT_CH_OUT,
	output logic CONVERTING_OUT,
	output logic VREF_POS_EXT_OUT,
	output logic VREF_NEG_EXT_OUT,
	output logic RES_VALID_OUT,
	output logic [15:0] RES_DATA_OUT,
	output logic [7:0] RES_ADDR_OUT,
	output logic DMA_REQ_OUT,
	output logic IRQ_FLAG_OUT
);

	// whole state of the block except the conversion clock divider
	typedef struct packed {
		asc_state_t state;        // sequencer state
		logic [15:0] con1;        // control_one storage
		logic [15:0] con2;        // control_two storage
		logic [15:0] con3;        // control_three storage
		logic [2:0] dma_len;      // log2 of dma words per channel
		logic irq;                // conversion_irq_flag
		logic buffer_half_status;               // buffer_half_status
		logic [4:0] tcnt;         // conversion clock count in a phase
		logic [1:0] ch;           // current channel
		logic [3:0] smp_cnt;      // conversions since last flag
		logic [3:0] buf_idx;      // standalone buffer index
		logic [7:0] ptr;          // dma pointer within a channel block
		logic trig_prev;          // last pin trigger level
		logic ack;                // bus acknowledge
		logic [31:0] rdata;       // bus read data
		logic res_valid;          // result strobe
		logic [15:0] res_data;    // formatted result
		logic [7:0] res_addr;     // dma address of result
		logic dma_req;            // dma request pulse
		logic [3:0] sample_ch;    // sample/hold channels sampling
		logic converting;         // conversion in progress
		logic vpos;               // external positive reference
		logic vneg;               // external negative reference
	} asc_core_t;

	asc_core_t s;
	asc_core_t n;

	logic tad;                    // conversion clock enable
	logic [15:0] fmt_word;        // formatted converter code
	logic div_run;                // divider runs while sequencing

	// last channel index from resolution and channel count
	function automatic logic [1:0] last_chan(input logic res12, input logic [1:0] cnt);
		logic [1:0] r;
		r = 2'h0;
		if (res12) begin
			r = 2'h0;
		end else if (cnt[1]) begin
			r = 2'h3;
		end else if (cnt[0]) begin
			r = 2'h1;
		end
		return r;
	endfunction

	// merge written bits into a stored register
	function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [15:0] dat,
		input logic [15:0] msk);
		return (old & ~msk) | (dat & msk);
	endfunction

	// divider runs only while the sequencer is active and not halted
	assign div_run = s.con1[C1_CONVERTER_ON] && (s.state != ST_IDLE)
		&& !(s.con1[C1_IDLE_HALT] && IDLE_MODE_IN);

	// conversion clock divider
	asc_tad_div asc_tad_div_inst (
		.clk_in(CORE_CLK_IN),
		.rst_in(RST_IN),
		.run_in(div_run),
		.div_in(s.con3[C3_DIVIDER_LSB +: 8]),
		.tick_out(tad)
	);

	// result formatter
	asc_fmt asc_fmt_inst (
		.code_in(ANALOG_CODE_IN),
		.format_in(s.con1[C1_FORMAT_LSB +: 2]),
		.res12_in(s.con1[C1_RESOLUTION]),
		.word_out(fmt_word)
	);

	// next-state logic: bus first, then hardware events so sets win
	always_comb begin
		logic bus_req;            // request taken this cycle
		logic [15:0] bm;          // byte write mask
		logic res12;              // 12-bit mode
		logic sim;                // effective simultaneous mode
		logic [1:0] last;         // last channel index
		logic [2:0] trig;         // trigger source
		logic [3:0] samples_per_interrupt;         // samples per interrupt
		logic [4:0] samc;         // sample time in conversion clocks
		logic [4:0] conv_last;    // last count of a conversion
		logic [7:0] len_mask;     // dma block mask
		logic halt;               // idle mode halt
		logic end_smp;            // sampling ends
		logic seq_end;            // whole sequence done
		logic [15:0] rd;          // register read value
		n = s;
		bus_req = WB_CYC_IN && WB_STB_IN && !s.ack;
		bm = {{8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
		res12 = 1'b0;
		sim = 1'b0;
		last = 2'h0;
		trig = 3'h0;
		samples_per_interrupt = 4'h0;
		samc = 5'h0;
		conv_last = 5'h0;
		len_mask = 8'h00;
		halt = 1'b0;
		end_smp = 1'b0;
		seq_end = 1'b0;
		rd = 16'h0000;
		n.ack = 1'b0;
		n.res_valid = 1'b0;
		n.dma_req = 1'b0;
		n.trig_prev = EXT_TRIG_IN;

		// bus access, acknowledged in the following cycle
		if (bus_req) begin
			n.ack = 1'b1;
			if (WB_WE_IN) begin
				if (WB_ADR_IN == REG_CONTROL_ONE_ADDR) begin
					n.con1 = wmerge(s.con1, WB_DAT_IN[15:0], C1_WMASK & bm);
					if (WB_SEL_IN[0] && !WB_DAT_IN[C1_DONE]) begin
						n.con1[C1_DONE] = 1'b0;
					end
				end else if (WB_ADR_IN == REG_CONTROL_TWO_ADDR) begin
					n.con2 = wmerge(s.con2, WB_DAT_IN[15:0], C2_WMASK & bm);
				end else if (WB_ADR_IN == REG_CONTROL_THREE_ADDR) begin
					n.con3 = wmerge(s.con3, WB_DAT_IN[15:0], C3_WMASK & bm);
				end else if (WB_ADR_IN == REG_AUX_ADDR) begin
					// flag clears on a zero write only
					if (WB_SEL_IN[1] && !WB_DAT_IN[AUX_IRQ_FLAG]) begin
						n.irq = 1'b0;
					end
					if (WB_SEL_IN[0]) begin
						n.dma_len = WB_DAT_IN[AUX_LEN_LSB +: 3];
					end
				end
			end else begin
				// read mux; unmapped addresses read zero
				if (WB_ADR_IN == REG_CONTROL_ONE_ADDR) begin
					rd = s.con1;
					rd[C1_SIMULTANEOUS] = s.con1[C1_SIMULTANEOUS]
						& ~s.con1[C1_RESOLUTION];
				end else if (WB_ADR_IN == REG_CONTROL_TWO_ADDR) begin
					rd = s.con2;
					if (s.con1[C1_RESOLUTION]) begin
						rd[C2_CHANNEL_COUNT_LSB +: 2] = 2'h0;
					end
					rd[C2_HALF_STATUS] = s.buffer_half_status;
				end else if (WB_ADR_IN == REG_CONTROL_THREE_ADDR) begin
					rd = s.con3;
				end else if (WB_ADR_IN == REG_AUX_ADDR) begin
					rd = {7'h00, s.irq, 5'h00, s.dma_len};
				end else if (WB_ADR_IN == REG_RESULT_ADDR) begin
					rd = s.res_data;
				end
				n.rdata = {16'h0000, rd};
			end
		end

		// configuration as seen after this cycle's write
		res12 = n.con1[C1_RESOLUTION];
		sim = n.con1[C1_SIMULTANEOUS] && !res12;
		last = last_chan(res12, n.con2[C2_CHANNEL_COUNT_LSB +: 2]);
		trig = n.con1[C1_TRIGGER_LSB +: 3];
		samples_per_interrupt = n.con2[C2_SAMPLES_LSB +: 4];
		samc = n.con3[C3_SAMPLE_TIME_LSB +: 5];
		if (samc == 5'h00) begin
			samc = 5'h01;
		end
		conv_last = (res12 ? CONV_TADS_12 : CONV_TADS_10) - 5'h01;
		len_mask = 8'((9'h001 << n.dma_len) - 9'h001);
		halt = n.con1[C1_IDLE_HALT] && IDLE_MODE_IN;

		// sequencer
		if (!n.con1[C1_CONVERTER_ON]) begin
			// module off: park everything
			n.state = ST_IDLE;
			n.con1[C1_SAMPLE_CTRL] = 1'b0;
			n.tcnt = 5'h00;
			n.ch = 2'h0;
			// restart buffer filling so a new run begins at its first slot
			n.smp_cnt = 4'h0;
			n.buf_idx = 4'h0;
			n.ptr = 8'h00;
			n.buffer_half_status = 1'b0;
		end else if (!halt) begin
			case (s.state)
				ST_IDLE: begin
					if (n.con1[C1_AUTO_SAMPLE]) begin
						n.con1[C1_SAMPLE_CTRL] = 1'b1;
					end
					if (n.con1[C1_SAMPLE_CTRL]) begin
						n.state = ST_SAMPLE;
						n.tcnt = 5'h00;
					end
				end
				ST_SAMPLE: begin
					// choose what ends sampling
					case (trig)
						TRIG_MANUAL: begin
							end_smp = !n.con1[C1_SAMPLE_CTRL];
						end
						TRIG_PIN: begin
							end_smp = EXT_TRIG_IN && !s.trig_prev;
						end
						TRIG_TIMER: begin
							end_smp = TIMER_MATCH_IN;
						end
						TRIG_AUTO: begin
							if (tad) begin
								n.tcnt = s.tcnt + 5'h01;
								end_smp = (n.tcnt >= samc);
							end
						end
						default: begin
							end_smp = 1'b0;
						end
					endcase
					if (end_smp) begin
						n.con1[C1_SAMPLE_CTRL] = 1'b0;
						n.con1[C1_DONE] = 1'b0;
						n.state = ST_CONVERT;
						n.tcnt = 5'h00;
					end else if (!n.con1[C1_SAMPLE_CTRL]) begin
						// software withdrew sampling under a hardware trigger
						n.state = ST_IDLE;
					end
				end
				ST_CONVERT: begin
					if (tad) begin
						if (s.tcnt == conv_last) begin
							// conversion complete: deliver result
							n.tcnt = 5'h00;
							n.res_valid = 1'b1;
							n.res_data = fmt_word;
							if (n.con1[C1_DMA_ORDER]) begin
								n.res_addr = {4'h0, s.buf_idx};
							end else begin
								n.res_addr = 8'({6'h00, s.ch} << s.dma_len)
									| (s.ptr & len_mask);
							end
							// count conversions towards the flag
							if (s.smp_cnt >= samples_per_interrupt) begin
								n.smp_cnt = 4'h0;
								n.buf_idx = 4'h0;
								n.irq = 1'b1;
								n.dma_req = 1'b1;
								n.ptr = (s.ptr + 8'h01) & len_mask;
								if (n.con2[C2_FILL_MODE]) begin
									n.buffer_half_status = ~s.buffer_half_status;
								end
							end else begin
								n.smp_cnt = s.smp_cnt + 4'h1;
								n.buf_idx = s.buf_idx + 4'h1;
							end
							// step channel; simultaneous mode converts held channels
							seq_end = !sim || (s.ch == last);
							n.ch = (s.ch >= last) ? 2'h0 : s.ch + 2'h1;
							if (!seq_end) begin
								n.con1[C1_DONE] = 1'b0;
							end else begin
								n.con1[C1_DONE] = 1'b1;
								if (n.con1[C1_AUTO_SAMPLE]) begin
									n.con1[C1_SAMPLE_CTRL] = 1'b1;
									n.state = ST_SAMPLE;
								end else begin
									n.state = ST_IDLE;
								end
							end
						end else begin
							n.tcnt = s.tcnt + 5'h01;
						end
					end
				end
				default: begin
					n.state = ST_IDLE;
				end
			endcase
		end

		// registered status outputs
		n.converting = (n.state == ST_CONVERT);
		if (n.state != ST_SAMPLE) begin
			n.sample_ch = 4'h0;
		end else if (sim) begin
			n.sample_ch = last[1] ? 4'hf : 4'h3;
		end else begin
			n.sample_ch = 4'(4'h1 << n.ch);
		end
		// reference selection
		case (n.con2[C2_REFERENCE_LSB +: 3])
			3'h1: begin
				n.vpos = 1'b1;
				n.vneg = 1'b0;
			end
			3'h2: begin
				n.vpos = 1'b0;
				n.vneg = 1'b1;
			end
			3'h3: begin
				n.vpos = 1'b1;
				n.vneg = 1'b1;
			end
			default: begin
				n.vpos = 1'b0;
				n.vneg = 1'b0;
			end
		endcase
	end

	// state register with constant reset values
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			s <= '{state: ST_IDLE, con1: C1_RESET, con2: C2_RESET, con3: C3_RESET,
				dma_len: AUX_LEN_RESET, default: '0};
		end else begin
			s <= n;
		end
	end

	// outputs straight from the state register
	assign WB_DAT_OUT = s.rdata;
	assign WB_ACK_OUT = s.ack;
	assign SAMPLE_CH_OUT = s.sample_ch;
	assign CONVERT_CH_OUT = s.ch;
	assign CONVERTING_OUT = s.converting;
	assign VREF_POS_EXT_OUT = s.vpos;
	assign VREF_NEG_EXT_OUT = s.vneg;
	assign RES_VALID_OUT = s.res_valid;
	assign RES_DATA_OUT = s.res_data;
	assign RES_ADDR_OUT = s.res_addr;
	assign DMA_REQ_OUT = s.dma_req;
	assign IRQ_FLAG_OUT = s.irq;

endmodule
`default_nettype wire

// >>> core/asc_pkg.sv
// package for the converter sequencing control block
// holds register offsets, field positions, reset values, codes and cycle counts
package asc_pkg;

	// wishbone register byte addresses
	localparam logic [7:0] REG_CONTROL_ONE_ADDR = 8'h00;
	localparam logic [7:0] REG_CONTROL_TWO_ADDR = 8'h04;
	localparam logic [7:0] REG_CONTROL_THREE_ADDR = 8'h08;
	localparam logic [7:0] REG_AUX_ADDR = 8'h0c;
	localparam logic [7:0] REG_RESULT_ADDR = 8'h10;

	// control_one field positions
	localparam int C1_CONVERTER_ON = 15;
	localparam int C1_IDLE_HALT = 13;
	localparam int C1_DMA_ORDER = 12;
	localparam int C1_RESOLUTION = 10;
	localparam int C1_FORMAT_LSB = 8;
	localparam int C1_TRIGGER_LSB = 5;
	localparam int C1_SIMULTANEOUS = 3;
	localparam int C1_AUTO_SAMPLE = 2;
	localparam int C1_SAMPLE_CTRL = 1;
	localparam int C1_DONE = 0;

	// control_two field positions
	localparam int C2_REFERENCE_LSB = 13;
	localparam int C2_CHANNEL_COUNT_LSB = 8;
	localparam int C2_HALF_STATUS = 7;
	localparam int C2_SAMPLES_LSB = 2;
	localparam int C2_FILL_MODE = 1;

	// control_three field positions
	localparam int C3_SAMPLE_TIME_LSB = 8;
	localparam int C3_DIVIDER_LSB = 0;

	// aux register field positions
	localparam int AUX_IRQ_FLAG = 8;
	localparam int AUX_LEN_LSB = 0;

	// writable bits of each control register
	localparam logic [15:0] C1_WMASK = 16'hb7ee;
	localparam logic [15:0] C2_WMASK = 16'he73f;
	localparam logic [15:0] C3_WMASK = 16'h1fff;

	// values after reset
	localparam logic [15:0] C1_RESET = 16'h0000;
	localparam logic [15:0] C2_RESET = 16'h0000;
	localparam logic [15:0] C3_RESET = 16'h0000;
	localparam logic [2:0] AUX_LEN_RESET = 3'h3;

	// conversion length in conversion clock periods
	localparam logic [4:0] CONV_TADS_10 = 5'h0c;
	localparam logic [4:0] CONV_TADS_12 = 5'h0e;

	// trigger source codes
	localparam logic [2:0] TRIG_MANUAL = 3'h0;
	localparam logic [2:0] TRIG_PIN = 3'h1;
	localparam logic [2:0] TRIG_TIMER = 3'h2;
	localparam logic [2:0] TRIG_AUTO = 3'h7;

	// output format codes
	localparam logic [1:0] FMT_INT = 2'h0;
	localparam logic [1:0] FMT_SINT = 2'h1;
	localparam logic [1:0] FMT_FRAC = 2'h2;
	localparam logic [1:0] FMT_SFRAC = 2'h3;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_CONVERT = 2'b10
	} asc_state_t;

endpackage

// >>> core/asc_tad_div.sv
// conversion clock divider: one-cycle enable every (divider + 1) clocks
// assumes the core clock is the instruction clock
`timescale 1ns/1ps
`default_nettype none
module asc_tad_div
	import asc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic run_in,
	input wire logic [7:0] div_in,
	output logic tick_out
);
	// divider state
	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} asc_div_t;

	asc_div_t s;
	asc_div_t n;

	// restart phase whenever stopped so the first period is whole
	always_comb begin
		n = s;
		n.tick = 1'b0;
		if (!run_in) begin
			n.cnt = 8'h00;
		end else if (s.cnt == div_in) begin
			n.cnt = 8'h00;
			n.tick = 1'b1;
		end else begin
			n.cnt = s.cnt + 8'h01;
		end
	end

	// state register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tick_out = s.tick;
endmodule
`default_nettype wire

// >>> core/asc_fmt.sv
// result formatter: raw converter code to the 16-bit output word
// purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module asc_fmt
	import asc_pkg::*;
(
	input wire logic [11:0] code_in,
	input wire logic [1:0] format_in,
	input wire logic res12_in,
	output logic [15:0] word_out
);
	// format selection per resolution
	always_comb begin
		word_out = 16'h0000;
		if (res12_in) begin
			case (format_in)
				FMT_INT: word_out = {4'h0, code_in};
				FMT_SINT: word_out = {{5{~code_in[11]}}, code_in[10:0]};
				FMT_FRAC: word_out = {code_in, 4'h0};
				default: word_out = {~code_in[11], code_in[10:0], 4'h0};
			endcase
		end else begin
			case (format_in)
				FMT_INT: word_out = {6'h00, code_in[9:0]};
				FMT_SINT: word_out = {{7{~code_in[9]}}, code_in[8:0]};
				FMT_FRAC: word_out = {code_in[9:0], 6'h00};
				default: word_out = {~code_in[9], code_in[8:0], 6'h00};
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> sim/asc_analog_model.sv
// analog core stand-in: answers each conversion with a code per channel
// assumes the bench sets the base code before the conversion starts
`timescale 1ns/1ps
`default_nettype none
module asc_analog_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic conv_in,
	input wire logic [1:0] ch_in,
	input wire logic [11:0] base_in,
	output logic [11:0] code_out
);
	logic [11:0] last_ff; // last code held
	// remember the held code so the idle line can show its inverse
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			last_ff <= 12'h000;
		end else if (conv_in) begin
			last_ff <= code_out;
		end
	end
	// code is valid only while converting
	assign code_out = conv_in ? (base_in ^ {10'h000, ch_in}) : ~last_ff;
endmodule
`default_nettype wire

// >>> sim/asc_top_assertions.sv
// port checker for asc_top, bound to every instance
// shadows the control writes it needs from the wishbone port
`timescale 1ns/1ps
`default_nettype none
module asc_top_assertions
	import asc_pkg::*;
(
	input wire logic CORE_CLK_IN,
	input wire logic RST_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	input wire logic WB_ACK_OUT,
	input wire logic IDLE_MODE_IN,
	input wire logic CONVERTING_OUT,
	input wire logic VREF_POS_EXT_OUT,
	input wire logic VREF_NEG_EXT_OUT,
	input wire logic RES_VALID_OUT,
	input wire logic DMA_REQ_OUT,
	input wire logic IRQ_FLAG_OUT
);
	logic take; // upper byte write taken
	logic on_ff;
	logic halt_ff;
	logic [2:0] ref_ff;
	assign take = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !WB_ACK_OUT && WB_SEL_IN[1];
	// shadow of converter_on, idle_halt and reference_config
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			on_ff <= 1'b0;
			halt_ff <= 1'b0;
			ref_ff <= 3'h0;
		end else if (take && WB_ADR_IN == REG_CONTROL_ONE_ADDR) begin
			on_ff <= WB_DAT_IN[C1_CONVERTER_ON];
			halt_ff <= WB_DAT_IN[C1_IDLE_HALT];
		end else if (take && WB_ADR_IN == REG_CONTROL_TWO_ADDR) begin
			ref_ff <= WB_DAT_IN[C2_REFERENCE_LSB +: 3];
		end
	end
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	AST_ACK_LATENCY: assert property ((WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |=> WB_ACK_OUT)
		else $error("ack late");
	AST_ACK_PULSE: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack too long");
	AST_OFF_IDLE: assert property (!on_ff [*3] |-> !CONVERTING_OUT && !RES_VALID_OUT)
		else $error("activity while off");
	AST_REF_OUT: assert property ($stable(ref_ff) |->
		VREF_POS_EXT_OUT == (ref_ff == 3'h1 || ref_ff == 3'h3) &&
		VREF_NEG_EXT_OUT == (ref_ff == 3'h2 || ref_ff == 3'h3))
		else $error("reference select wrong");
	AST_IDLE_FREEZE: assert property ((halt_ff && IDLE_MODE_IN) [*3] |->
		!RES_VALID_OUT && $stable(CONVERTING_OUT))
		else $error("progress in idle");
	AST_DMA_FLAG: assert property (DMA_REQ_OUT |-> IRQ_FLAG_OUT && RES_VALID_OUT)
		else $error("dma without flag");
	AST_FLAG_DMA: assert property ($rose(IRQ_FLAG_OUT) |-> DMA_REQ_OUT)
		else $error("flag without dma");
	AST_DMA_PULSE: assert property (DMA_REQ_OUT |=> !DMA_REQ_OUT)
		else $error("dma too long");
	AST_RES_CONV: assert property (RES_VALID_OUT |-> $past(CONVERTING_OUT) ##1 !RES_VALID_OUT)
		else $error("result without conversion");
	COV_RES: cover property (RES_VALID_OUT);
	COV_DMA: cover property (DMA_REQ_OUT);
	COV_IDLE: cover property (halt_ff && IDLE_MODE_IN && CONVERTING_OUT);
endmodule
bind asc_top asc_top_assertions asc_top_assertions_inst (.CORE_CLK_IN(CORE_CLK_IN),
	.RST_IN(RST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN),
	.WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
	.WB_ACK_OUT(WB_ACK_OUT), .IDLE_MODE_IN(IDLE_MODE_IN), .CONVERTING_OUT(CONVERTING_OUT),
	.VREF_POS_EXT_OUT(VREF_POS_EXT_OUT), .VREF_NEG_EXT_OUT(VREF_NEG_EXT_OUT),
	.RES_VALID_OUT(RES_VALID_OUT), .DMA_REQ_OUT(DMA_REQ_OUT), .IRQ_FLAG_OUT(IRQ_FLAG_OUT));
`default_nettype wire

// >>> sim/test_adc_sequencer_control.sv
// self-checking bench for the converter control block
// acts as software on wishbone; the analog model answers conversions
`timescale 1ns/1ps
`default_nettype none
module test_adc_sequencer_control;
	import asc_pkg::*;
	logic clk, rst, cyc, stb, we, ack, idle, trig, tmr, conv, vp, vn, rv, dreq, irq;
	logic [7:0] adr, raddr;
	logic [3:0] sel, sch;
	logic [31:0] wdat, rdat;
	logic [11:0] acode, base;
	logic [1:0] cch;
	logic [15:0] rdata, q, c1;
	int error_cnt = 0;
	int check_count = 0;
	int n, dv, t;
	asc_top asc_top_inst (.CORE_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
		.WB_ACK_OUT(ack), .IDLE_MODE_IN(idle), .EXT_TRIG_IN(trig), .TIMER_MATCH_IN(tmr),
		.ANALOG_CODE_IN(acode), .SAMPLE_CH_OUT(sch), .CONVERT_CH_OUT(cch), .CONVERTING_OUT(conv),
		.VREF_POS_EXT_OUT(vp), .VREF_NEG_EXT_OUT(vn), .RES_VALID_OUT(rv), .RES_DATA_OUT(rdata),
		.RES_ADDR_OUT(raddr), .DMA_REQ_OUT(dreq), .IRQ_FLAG_OUT(irq));
	asc_analog_model asc_analog_model_inst (.clk_in(clk), .rst_in(rst), .conv_in(conv),
		.ch_in(cch), .base_in(base), .code_out(acode));
	// verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// counted comparison
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// classic single cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 100);
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
		if (n >= 100) begin
			error_cnt++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		chk(q, e);
	endtask
	// waits for a result strobe, n gives the cycles waited
	task automatic wait_res();
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rv !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			error_cnt++;
			conclude();
		end
	endtask
	// expected output word for a raw code
	function automatic logic [15:0] fmt_exp(input logic [11:0] c, input int f, input bit r12);
		case (f)
			0: fmt_exp = r12 ? {4'h0, c} : {6'h00, c[9:0]};
			1: fmt_exp = r12 ? {{5{~c[11]}}, c[10:0]} : {{7{~c[9]}}, c[8:0]};
			2: fmt_exp = r12 ? {c, 4'h0} : {c[9:0], 6'h00};
			default: fmt_exp = r12 ? {~c[11], c[10:0], 4'h0} : {~c[9], c[8:0], 6'h00};
		endcase
	endfunction
	// free-running core clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		conclude();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		{cyc, stb, we, idle, trig, tmr} = 6'h00;
		adr = 8'h00;
		sel = 4'h3;
		wdat = 32'h0;
		base = 12'h000;
		n = $urandom(92004);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk(REG_CONTROL_ONE_ADDR, C1_RESET);
		rd_chk(REG_CONTROL_TWO_ADDR, C2_RESET);
		rd_chk(REG_AUX_ADDR, {13'h0000, AUX_LEN_RESET});
		wr(8'h14, 16'hffff);
		rd_chk(8'h14, 16'h0000);
		c1 = 16'($urandom);
		wr(REG_CONTROL_THREE_ADDR, c1);
		rd_chk(REG_CONTROL_THREE_ADDR, c1 & C3_WMASK);
		wr(REG_CONTROL_ONE_ADDR, 16'h0409);
		rd_chk(REG_CONTROL_ONE_ADDR, 16'h0400);
		for (int i = 0; i < 8; i++) begin
			wr(REG_CONTROL_TWO_ADDR, 16'(i << 13));
			chk({14'h0, vp, vn}, {14'h0, i == 1 || i == 3, i == 2 || i == 3});
		end
		$display("test registers done");
		for (int r = 0; r < 2; r++) begin
			for (int f = 0; f < 4; f++) begin
				dv = $urandom_range(3);
				base <= 12'($urandom);
				c1 = 16'((r << 10) | (f << 8));
				wr(REG_CONTROL_ONE_ADDR, 16'h0000);
				wr(REG_CONTROL_THREE_ADDR, 16'(dv));
				wr(REG_CONTROL_TWO_ADDR, 16'h0000);
				wr(REG_AUX_ADDR, 16'h0003);
				wr(REG_CONTROL_ONE_ADDR, c1);
				wr(REG_CONTROL_ONE_ADDR, c1 | 16'h8000);
				wr(REG_CONTROL_ONE_ADDR, c1 | 16'h8002);
				repeat (3) @(posedge clk);
				wr(REG_CONTROL_ONE_ADDR, c1 | 16'h8000);
				wait_res();
				t = (r ? 14 : 12) * (dv + 1);
				chk(16'(n >= t - dv - 1 && n <= t - 1), 16'h0001);
				chk(rdata, fmt_exp(base, f, r[0]));
				rd_chk(REG_CONTROL_ONE_ADDR, c1 | 16'h8001);
				chk({15'h0, irq}, 16'h0001);
			end
		end
		$display("test formats done");
		for (int m = 0; m < 2; m++) begin
			wr(REG_CONTROL_ONE_ADDR, 16'h0000);
			wr(REG_AUX_ADDR, 16'h0003);
			wr(REG_CONTROL_THREE_ADDR, 16'h0200);
			wr(REG_CONTROL_TWO_ADDR, m ? 16'h0002 : 16'h0004);
			wr(REG_CONTROL_ONE_ADDR, m ? 16'h80e6 : 16'h90e6);
			for (int k = 0; k < 3; k++) begin
				wait_res();
				chk({8'h00, raddr}, m ? 16'(k) : 16'(k % 2));
				if (k == 0) begin
					repeat (2) @(posedge clk);
					chk({15'h0, irq}, 16'(m));
					for (n = 0; n < 50 && conv !== 1'b1; n++) @(posedge clk);
					rd_chk(REG_CONTROL_ONE_ADDR, m ? 16'h80e4 : 16'h90e4);
					rd_chk(REG_CONTROL_TWO_ADDR, m ? 16'h0082 : 16'h0004);
				end
			end
		end
		$display("test auto dma done");
		for (int g = 1; g < 3; g++) begin
			c1 = 16'h8002 | 16'(g << 5);
			wr(REG_CONTROL_ONE_ADDR, 16'h0000);
			wr(REG_CONTROL_ONE_ADDR, c1);
			repeat (4) @(posedge clk);
			trig <= (g == 1);
			tmr <= (g == 2);
			@(posedge clk);
			trig <= 1'b0;
			tmr <= 1'b0;
			wait_res();
			rd_chk(REG_CONTROL_ONE_ADDR, c1 ^ 16'h0003);
		end
		$display("test triggers done");
		for (int s = 0; s < 3; s++) begin
			wr(REG_CONTROL_ONE_ADDR, 16'h0000);
			wr(REG_CONTROL_TWO_ADDR, s == 1 ? 16'h0100 : 16'h0200);
			wr(REG_CONTROL_ONE_ADDR, s == 2 ? 16'h840a : 16'h800a);
			repeat (2) @(posedge clk);
			chk({12'h000, sch}, s == 0 ? 16'h000f : (s == 1 ? 16'h0003 : 16'h0001));
			wr(REG_CONTROL_ONE_ADDR, s == 2 ? 16'h8408 : 16'h8008);
			// held channels convert back to back, one result each
			t = (s == 0) ? 4 : (s == 1 ? 2 : 1);
			for (int j = 0; j < t; j++) begin
				wait_res();
				chk(rdata, fmt_exp(base ^ 12'(j), 0, s == 2));
				chk({14'h0000, cch}, 16'((j + 1) % t));
				chk({8'h00, raddr}, 16'(j * 9));
			end
		end
		$display("test simultaneous done");
		wr(REG_CONTROL_ONE_ADDR, 16'h0000);
		wr(REG_CONTROL_THREE_ADDR, 16'h0003);
		wr(REG_CONTROL_ONE_ADDR, 16'ha002);
		wr(REG_CONTROL_ONE_ADDR, 16'ha000);
		idle <= 1'b1;
		repeat (100) @(posedge clk);
		chk({15'h0, conv}, 16'h0001);
		idle <= 1'b0;
		wait_res();
		chk(rdata, fmt_exp(base, 0, 1'b0));
		$display("test idle halt done");
		conclude();
	end
endmodule
`default_nettype wire
